// File: core/dspoc_pkg.sv
// Purpose: shared constants and carrier types for the slice operand control block
// Assumes: single core clock, synchronous active-high resets
// Notes:   all select encodings and register offsets live here and nowhere else
package dspoc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned DW       = 48;  // adder datapath width
  localparam int unsigned AW       = 30;  // a port width
  localparam int unsigned MAW      = 25;  // multiplier a operand / d port width
  localparam int unsigned BW       = 18;  // b port width
  localparam int unsigned PPW      = 43;  // partial product width
  localparam int unsigned IMW      = 5;   // input-mode control width
  localparam int unsigned ZSHIFT   = 17;  // right shift of the z shift selections
  localparam int unsigned REG_AW   = 4;   // register port address width

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [REG_AW-1:0] OFS_CFG  = 4'h0;
  localparam logic [REG_AW-1:0] OFS_STAT = 4'h4;
  localparam logic [31:0]       CFG_RST  = 32'h0000_0000;
  localparam int unsigned CFG_IMODE_REG = 0;  // input-mode register used
  localparam int unsigned CFG_OPSEL_REG = 1;  // operand select register used
  localparam int unsigned CFG_ALU_REG   = 2;  // alu op register used
  localparam int unsigned CFG_CSEL_REG  = 3;  // carry source register used
  localparam int unsigned CFG_FCIN_REG  = 4;  // fabric carry registered
  localparam int unsigned CFG_RND_REG   = 5;  // rounding carry registered
  localparam int unsigned CFG_DPORT     = 6;  // pre-adder d port in use
  localparam int unsigned CFG_ADD_LSB   = 8;  // addend stage count, 2 bits

  // ****************************************************************
  // select encodings
  // ****************************************************************
  localparam logic [1:0] X_ZERO = 2'h0;
  localparam logic [1:0] X_PROD = 2'h1;
  localparam logic [1:0] X_RES  = 2'h2;
  localparam logic [1:0] X_AB   = 2'h3;
  localparam logic [1:0] Y_ZERO = 2'h0;
  localparam logic [1:0] Y_PROD = 2'h1;
  localparam logic [1:0] Y_ONES = 2'h2;
  localparam logic [1:0] Y_ADD  = 2'h3;
  localparam logic [2:0] Z_ZERO = 3'h0;
  localparam logic [2:0] Z_CSUM = 3'h1;
  localparam logic [2:0] Z_RES  = 3'h2;
  localparam logic [2:0] Z_ADD  = 3'h3;
  localparam logic [2:0] Z_MEXT = 3'h4;
  localparam logic [2:0] Z_CSHR = 3'h5;
  localparam logic [2:0] Z_RSHR = 3'h6;
  localparam logic [3:0] ALU_ADD   = 4'h0;
  localparam logic [3:0] ALU_NZADD = 4'h1;
  localparam logic [3:0] ALU_NSUM  = 4'h2;
  localparam logic [3:0] ALU_SUB   = 4'h3;
  localparam logic [2:0] C_FABRIC  = 3'h0;
  localparam logic [2:0] C_NCSUM   = 3'h1;
  localparam logic [2:0] C_CASCIN  = 3'h2;
  localparam logic [2:0] C_CSUM    = 3'h3;
  localparam logic [2:0] C_FEEDBK  = 3'h4;
  localparam logic [2:0] C_NRES    = 3'h5;
  localparam logic [2:0] C_ROUND   = 3'h6;
  localparam logic [2:0] C_RES     = 3'h7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [6:0] opsel;  // z[6:4], y[3:2], x[1:0]
    logic [3:0] alu;
    logic [2:0] csel;
  } dspoc_ctrl_t;

endpackage : dspoc_pkg

// File: core/dspoc_operand_ctrl.sv
// Purpose: operand selection, pre-adder, control registers and alu of a mac slice
// Assumes: controls and data come from logic on i_core_clk; no synchronisers needed
// Notes:   every output is registered, so each result shows one cycle after its
//          effective controls; optional control registers add one cycle more
//
// The implementer's own choices: the register addresses and strobed register access.

// Functional notes
// RQ1 - input-mode bit0 picks first a stage
// RQ2 - input-mode bit1 zeroes pre-adder a operand
// RQ3 - input-mode bit2 low zeroes d operand
// RQ4 - input-mode bit3 makes pre-adder subtract
// RQ5 - input-mode bit4 picks first b stage
// RQ6 - addend feeds y and z multiplexers
// RQ7 - addend path has configurable pipeline stages
// RQ8 - control selects flow-through or registered
// RQ9 - control register resets and clock enables
// RQ10 - operand select may change every cycle
// RQ11 - x mux encodings, product pairs y
// RQ12 - y mux encodings
// RQ13 - z mux basic encodings
// RQ14 - z mux shifted encodings
// RQ15 - far side never uses z 111
// RQ16 - result selections need output register
// RQ17 - alu 0000 adds all
// RQ18 - alu 0011 subtracts from z
// RQ19 - alu 0001 and 0010 inverted forms
// RQ20 - carry sources fabric, cascade, feedback
// RQ21 - carry sources for rounding
// RQ22 - fabric and rounding carry optionally registered
// RQ23 - optional input-mode register
// RQ24 - d is 25 bits, a 30 bits
module dspoc_operand_ctrl
  import dspoc_pkg::*;
#(
  parameter int unsigned ADD_MAX = 2  // deepest addend pipeline
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [31:0]       o_reg_rdata,
  input  wire logic [IMW-1:0]    i_input_mode_sel,
  input  wire logic              i_input_mode_clk_en,
  input  wire logic              i_input_mode_sync_reset,
  input  wire dspoc_ctrl_t       i_ctrl,
  input  wire logic              i_opsel_clk_en,
  input  wire logic              i_csel_clk_en,
  input  wire logic              i_alu_clk_en,
  input  wire logic              i_ctrl_sync_reset,
  input  wire logic              i_alu_op_sync_reset,
  input  wire logic [AW-1:0]     i_a_first_stage,
  input  wire logic [AW-1:0]     i_a_second_stage,
  input  wire logic [MAW-1:0]    i_d_port,
  input  wire logic [BW-1:0]     i_b_first_stage,
  input  wire logic [BW-1:0]     i_b_second_stage,
  input  wire logic [DW-1:0]     i_addend,
  input  wire logic              i_addend_clk_en,
  input  wire logic              i_addend_sync_reset,
  input  wire logic [PPW-1:0]    i_pp_x,
  input  wire logic [PPW-1:0]    i_pp_y,
  input  wire logic [DW-1:0]     i_result,
  input  wire logic [DW-1:0]     i_cascaded_sum_in,
  input  wire logic              i_fabric_carry_in,
  input  wire logic              i_carry_clk_en,
  input  wire logic              i_carry_sync_reset,
  input  wire logic              i_cascaded_carry_in,
  input  wire logic              i_cascaded_carry_out,
  output logic      [MAW-1:0]    o_mult_a,
  output logic      [BW-1:0]     o_mult_b,
  output logic      [DW-1:0]     o_x_operand,
  output logic      [DW-1:0]     o_y_operand,
  output logic      [DW-1:0]     o_z_operand,
  output logic                   o_carry_in_value,
  output logic      [DW-1:0]     o_alu_result
);

  // ****************************************************************
  // configuration and status registers
  // ****************************************************************
  logic [31:0]    cfg_q;
  logic [IMW-1:0] imode_q;
  logic [IMW-1:0] imode;
  dspoc_ctrl_t    ctrl_q;
  dspoc_ctrl_t    ctrl;
  logic [31:0]    stat;
  logic [1:0]     add_stages;

  // static options written by software; steer the whole datapath
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cfg_q <= CFG_RST;
    end else if (i_reg_wr && i_reg_addr == OFS_CFG) begin
      cfg_q <= i_reg_wdata;
    end
  end

  assign stat = {13'h0000, ctrl, imode};

  // read data stand only in the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !i_reg_rd) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (i_reg_addr)
        OFS_CFG:  o_reg_rdata <= cfg_q;
        OFS_STAT: o_reg_rdata <= stat;
        default:  o_reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // input-mode register, own enable and reset
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_input_mode_sync_reset) begin
      imode_q <= 5'h00;  // [RQ23]
    end else if (i_input_mode_clk_en) begin
      imode_q <= i_input_mode_sel;
    end
  end

  // operand select and carry source share the control reset, separate enables
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_ctrl_sync_reset) begin
      ctrl_q.opsel <= 7'h00;  // [RQ9]
    end else if (i_opsel_clk_en) begin
      ctrl_q.opsel <= i_ctrl.opsel;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_ctrl_sync_reset) begin
      ctrl_q.csel <= 3'h0;  // [RQ9]
    end else if (i_csel_clk_en) begin
      ctrl_q.csel <= i_ctrl.csel;
    end
  end

  // alu op has its own reset so a running accumulate can keep its mode
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_alu_op_sync_reset) begin
      ctrl_q.alu <= 4'h0;  // [RQ9]
    end else if (i_alu_clk_en) begin
      ctrl_q.alu <= i_ctrl.alu;
    end
  end

  // flow-through trades fewer latency cycles for a longer path
  always_comb begin
    imode      = cfg_q[CFG_IMODE_REG] ? imode_q : i_input_mode_sel;        // [RQ23]
    ctrl.opsel = cfg_q[CFG_OPSEL_REG] ? ctrl_q.opsel : i_ctrl.opsel;       // [RQ8] [RQ10]
    ctrl.alu   = cfg_q[CFG_ALU_REG] ? ctrl_q.alu : i_ctrl.alu;             // [RQ8]
    ctrl.csel  = cfg_q[CFG_CSEL_REG] ? ctrl_q.csel : i_ctrl.csel;          // [RQ8]
  end

  // ****************************************************************
  // pre-adder and multiplier operands
  // ****************************************************************
  logic [MAW-1:0] a_sel;
  logic [MAW-1:0] a_op;
  logic [MAW-1:0] d_op;
  logic [MAW-1:0] mult_a;
  logic [BW-1:0]  mult_b;

  // only the low 25 a bits reach the multiplier path
  always_comb begin
    a_sel = imode[0] ? i_a_first_stage[MAW-1:0] : i_a_second_stage[MAW-1:0]; // [RQ1] [RQ24]
    a_op  = imode[1] ? '0 : a_sel;                                           // [RQ2]
    d_op  = imode[2] ? i_d_port : '0;                                        // [RQ3]
    if (!cfg_q[CFG_DPORT]) begin
      mult_a = a_op;  // pre-adder bypassed, d ignored
    end else if (imode[3]) begin
      mult_a = d_op - a_op;  // [RQ4]
    end else begin
      mult_a = d_op + a_op;  // [RQ4]
    end
    mult_b = imode[4] ? i_b_first_stage : i_b_second_stage;                  // [RQ5]
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_mult_a <= '0;
      o_mult_b <= '0;
    end else begin
      o_mult_a <= mult_a;
      o_mult_b <= mult_b;
    end
  end

  // ****************************************************************
  // addend pipeline
  // ****************************************************************
  logic [DW-1:0] add_pipe_q [ADD_MAX];
  logic [DW-1:0] addend;

  assign add_stages = cfg_q[CFG_ADD_LSB +: 2];

  // shift chain; the tap picked by the stage count feeds the muxes
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_addend_sync_reset) begin
      for (int i = 0; i < ADD_MAX; i++) begin
        add_pipe_q[i] <= '0;
      end
    end else if (i_addend_clk_en) begin
      add_pipe_q[0] <= i_addend;
      for (int i = 1; i < ADD_MAX; i++) begin
        add_pipe_q[i] <= add_pipe_q[i-1];
      end
    end
  end

  // counts beyond the deepest stage clamp to it
  always_comb begin
    if (add_stages == 2'h0) begin
      addend = i_addend;  // [RQ7]
    end else if (32'(add_stages) > ADD_MAX) begin
      addend = add_pipe_q[ADD_MAX-1];
    end else begin
      addend = add_pipe_q[32'(add_stages) - 1];  // [RQ7]
    end
  end

  // ****************************************************************
  // x, y and z multiplexers
  // ****************************************************************
  logic [DW-1:0] xm;
  logic [DW-1:0] ym;
  logic [DW-1:0] zm;

  // result selections are only meaningful with the output register fitted
  always_comb begin
    unique case (ctrl.opsel[1:0])
      X_ZERO: xm = '0;                                                // [RQ11]
      X_PROD: xm = {{(DW-PPW){i_pp_x[PPW-1]}}, i_pp_x};               // [RQ11]
      X_RES:  xm = i_result;                                          // [RQ16]
      X_AB:   xm = {i_a_second_stage, i_b_second_stage};              // [RQ11]
    endcase
    unique case (ctrl.opsel[3:2])
      Y_ZERO: ym = '0;                                                // [RQ12]
      Y_PROD: ym = {{(DW-PPW){i_pp_y[PPW-1]}}, i_pp_y};               // [RQ12]
      Y_ONES: ym = '1;                                                // [RQ12]
      Y_ADD:  ym = addend;                                            // [RQ6] [RQ12]
    endcase
    unique case (ctrl.opsel[6:4])
      Z_ZERO: zm = '0;                                                // [RQ13]
      Z_CSUM: zm = i_cascaded_sum_in;                                 // [RQ13]
      Z_RES,
      Z_MEXT: zm = i_result;                                          // [RQ13] [RQ16]
      Z_ADD:  zm = addend;                                            // [RQ6] [RQ13]
      Z_CSHR: zm = {{ZSHIFT{i_cascaded_sum_in[DW-1]}},
                    i_cascaded_sum_in[DW-1:ZSHIFT]};                  // [RQ14]
      Z_RSHR: zm = {{ZSHIFT{i_result[DW-1]}}, i_result[DW-1:ZSHIFT]}; // [RQ14]
      default: zm = '0;  // 111 is never applied; zero keeps it quiet [RQ15]
    endcase
  end

  // ****************************************************************
  // carry-in selection
  // ****************************************************************
  logic fcin_q;
  logic rnd_q;
  logic fcin;
  logic rnd;
  logic carry_in_value;

  // optional registers; rounding one matches the product register delay
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_carry_sync_reset) begin
      fcin_q <= 1'b0;
      rnd_q  <= 1'b0;
    end else if (i_carry_clk_en) begin
      fcin_q <= i_fabric_carry_in;                   // [RQ22]
      rnd_q  <= ~(mult_a[MAW-1] ^ mult_b[BW-1]);     // [RQ22]
    end
  end

  // carry source does not look at the operand select at all
  always_comb begin
    fcin = cfg_q[CFG_FCIN_REG] ? fcin_q : i_fabric_carry_in;
    rnd  = cfg_q[CFG_RND_REG] ? rnd_q : ~(mult_a[MAW-1] ^ mult_b[BW-1]);
    unique case (ctrl.csel)
      C_FABRIC: carry_in_value = fcin;                          // [RQ20]
      C_NCSUM:  carry_in_value = ~i_cascaded_sum_in[DW-1];      // [RQ21]
      C_CASCIN: carry_in_value = i_cascaded_carry_in;           // [RQ20]
      C_CSUM:   carry_in_value = i_cascaded_sum_in[DW-1];       // [RQ21]
      C_FEEDBK: carry_in_value = i_cascaded_carry_out;          // [RQ20] [RQ16]
      C_NRES:   carry_in_value = ~i_result[DW-1];               // [RQ21]
      C_ROUND:  carry_in_value = rnd;                           // [RQ21]
      C_RES:    carry_in_value = i_result[DW-1];                // [RQ21]
    endcase
  end

  // ****************************************************************
  // alu
  // ****************************************************************
  logic [DW-1:0] sum_xyc;
  logic [DW-1:0] alu;

  assign sum_xyc = xm + ym + {{(DW-1){1'b0}}, carry_in_value};

  // undefined alu codes give zero
  always_comb begin
    unique case (ctrl.alu)
      ALU_ADD:   alu = zm + sum_xyc;       // [RQ17]
      ALU_SUB:   alu = zm - sum_xyc;       // [RQ18]
      ALU_NZADD: alu = ~zm + sum_xyc;      // [RQ19]
      ALU_NSUM:  alu = ~(zm + sum_xyc);    // [RQ19]
      default:   alu = '0;
    endcase
  end

  // operands and result registered together, same cycle as their select
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_x_operand      <= '0;
      o_y_operand      <= '0;
      o_z_operand      <= '0;
      o_carry_in_value <= 1'b0;
      o_alu_result     <= '0;
    end else begin
      o_x_operand      <= xm;   // [RQ10]
      o_y_operand      <= ym;
      o_z_operand      <= zm;
      o_carry_in_value <= carry_in_value;
      o_alu_result     <= alu;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_select_a: assert property (imode[1:0] == 2'h1 && !cfg_q[CFG_DPORT]
    |=> o_mult_a == $past(i_a_first_stage[MAW-1:0])) // [RQ1]
    else $error("first a stage not routed");
  a_zero_a: assert property (imode[1] && !cfg_q[CFG_DPORT] |=> o_mult_a == '0) // [RQ2]
    else $error("a operand not forced to zero");
  d_zero_a: assert property (cfg_q[CFG_DPORT] && imode[2:1] == 2'h1
    |=> o_mult_a == '0) // [RQ3]
    else $error("d operand not forced to zero");
  preadd_sub_a: assert property (cfg_q[CFG_DPORT] && imode[3:1] == 3'h7
    |=> o_mult_a == $past(i_d_port)) // [RQ4]
    else $error("pre-adder subtract of zero wrong");
  b_select_a: assert property (imode[4] |=> o_mult_b == $past(i_b_first_stage)) // [RQ5]
    else $error("first b stage not routed");
  ctrl_reset_a: assert property (i_ctrl_sync_reset |=> ctrl_q.opsel == 7'h00
    && ctrl_q.csel == 3'h0) // [RQ9]
    else $error("control register not cleared");
  y_ones_a: assert property (ctrl.opsel[3:2] == Y_ONES |=> o_y_operand == '1) // [RQ12]
    else $error("y all-ones select wrong");
  z_addend_a: assert property (ctrl.opsel[6:4] == Z_ADD && add_stages == 2'h0
    |=> o_z_operand == $past(i_addend)) // [RQ6]
    else $error("z addend select wrong");
  alu_add_a: assert property (ctrl.alu == ALU_ADD
    |=> o_alu_result == o_x_operand + o_y_operand + o_z_operand
        + {{(DW-1){1'b0}}, o_carry_in_value}) // [RQ17]
    else $error("alu add wrong");
  alu_sub_a: assert property (ctrl.alu == ALU_SUB
    |=> o_alu_result == o_z_operand - (o_x_operand + o_y_operand
        + {{(DW-1){1'b0}}, o_carry_in_value})) // [RQ18]
    else $error("alu subtract wrong");
  carry_fabric_a: assert property (ctrl.csel == C_FABRIC && !cfg_q[CFG_FCIN_REG]
    |=> o_carry_in_value == $past(i_fabric_carry_in)) // [RQ20]
    else $error("fabric carry not selected");
  carry_cascaded_sum_in_a: assert property (ctrl.csel == C_NCSUM
    |=> o_carry_in_value == !$past(i_cascaded_sum_in[DW-1])) // [RQ21]
    else $error("inverted cascade sign not selected");

endmodule : dspoc_operand_ctrl

// File: tb/dspoc_fabric_model.sv
// Purpose: output register stage and cascade carry seen from the fabric side
// Assumes: the bench loads it once after reset
// Notes:   it never captures the alu result, so result selections stay predictable
module dspoc_fabric_model
  import dspoc_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire logic          i_srst,
  input  wire logic          i_load,
  input  wire logic [DW:0]   i_load_val,
  output logic      [DW-1:0] o_result,
  output logic               o_carry_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // output register stage
  // ************
  // always present, so result and feedback selections are legal
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      {o_carry_out, o_result} <= '0;
    end else if (i_load) begin
      {o_carry_out, o_result} <= i_load_val;
    end
  end
endmodule : dspoc_fabric_model

// File: tb/dspoc_operand_ctrl_tb.sv
// Purpose: self-checking bench for the slice operand control
// Assumes: flow-through controls answer one cycle after the inputs
// Notes:   data held constant so each control setting has one known answer
module dspoc_operand_ctrl_tb
  import dspoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // stimulus and observed signals
  // ************
  localparam logic [AW-1:0]  A1 = 30'h0055_5501;
  localparam logic [AW-1:0]  A2 = 30'h1100_0005;
  localparam logic [MAW-1:0] DV = 25'h123_4567;
  localparam logic [BW-1:0]  B1 = 18'h1_2345;
  localparam logic [BW-1:0]  B2 = 18'h2_0003;
  localparam logic [PPW-1:0] PX = 43'h400_0000_0123;
  localparam logic [PPW-1:0] PY = 43'h000_0010_0000;
  localparam logic [DW-1:0]  CS = 48'h1234_5678_9ABC;
  localparam logic [DW:0]    LV = {1'b1, 48'h0FED_CBA9_8765};
  localparam logic [DW-1:0]  A_OLD = 48'h0000_1111_2222;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [REG_AW-1:0] raddr = '0;
  logic [31:0]       wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [IMW-1:0]    imode = '0;
  logic [IMW-1:0]    pim = '0;
  dspoc_ctrl_t       ctrl = '0;
  dspoc_ctrl_t       pc = '0;
  dspoc_ctrl_t       c1, c2, e;
  logic              op_en = 1'b1, cs_en = 1'b1, alu_en = 1'b1, im_en = 1'b1;
  logic              ctrl_rst = 1'b0, alu_rst = 1'b0, aen = 1'b1, ld = 1'b0;
  logic              fab = 1'b0, cci = 1'b1, mc, oc, cco;
  logic [DW-1:0]     addend = A_OLD;
  logic [DW-1:0]     mx, my, mz, ma, ox, oy, oz, oalu, res;
  logic [MAW-1:0]    mma, oma;
  logic [BW-1:0]     mmb, omb;
  logic [31:0]       rdata;
  int                miscompares = 0;
  int                n_tests = 0;

  dspoc_fabric_model partner (.i_core_clk(clk), .i_srst(srst), .i_load(ld),
    .i_load_val(LV), .o_result(res), .o_carry_out(cco));

  dspoc_operand_ctrl #(.ADD_MAX(2)) dut (.i_core_clk(clk), .i_srst(srst),
    .i_reg_addr(raddr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(rdata), .i_input_mode_sel(imode), .i_input_mode_clk_en(im_en),
    .i_input_mode_sync_reset(1'b0), .i_ctrl(ctrl), .i_opsel_clk_en(op_en),
    .i_csel_clk_en(cs_en), .i_alu_clk_en(alu_en), .i_ctrl_sync_reset(ctrl_rst),
    .i_alu_op_sync_reset(alu_rst), .i_a_first_stage(A1), .i_a_second_stage(A2),
    .i_d_port(DV), .i_b_first_stage(B1), .i_b_second_stage(B2), .i_addend(addend),
    .i_addend_clk_en(aen), .i_addend_sync_reset(1'b0), .i_pp_x(PX), .i_pp_y(PY),
    .i_result(res), .i_cascaded_sum_in(CS), .i_fabric_carry_in(fab),
    .i_carry_clk_en(1'b1), .i_carry_sync_reset(1'b0), .i_cascaded_carry_in(cci),
    .i_cascaded_carry_out(cco), .o_mult_a(oma), .o_mult_b(omb), .o_x_operand(ox),
    .o_y_operand(oy), .o_z_operand(oz), .o_carry_in_value(oc), .o_alu_result(oalu));

  // free-running core clock, 8 ns
  initial begin
    forever #4 clk = ~clk;
  end
  // ************
  // expectations, compare and bus tasks
  // ************
  // f is the fabric carry that stood beside c; cascade carry is its inverse
  function automatic void model(input dspoc_ctrl_t c, input logic [IMW-1:0] im,
                                input logic f);
    logic [MAW-1:0] a;
    a = im[1] ? '0 : (im[0] ? A1[MAW-1:0] : A2[MAW-1:0]);
    mma = im[3] ? (im[2] ? DV : '0) - a : (im[2] ? DV : '0) + a;
    mmb = im[4] ? B1 : B2;
    case (c.opsel[1:0])
      X_ZERO:  mx = '0;
      X_PROD:  mx = {{(DW-PPW){PX[PPW-1]}}, PX};
      X_RES:   mx = LV[DW-1:0];
      default: mx = {A2, B2};
    endcase
    case (c.opsel[3:2])
      Y_ZERO:  my = '0;
      Y_PROD:  my = {{(DW-PPW){PY[PPW-1]}}, PY};
      Y_ONES:  my = '1;
      default: my = addend;
    endcase
    // sign bits of both shifted sources are 0, so either shift kind fits
    case (c.opsel[6:4])
      Z_CSUM:       mz = CS;
      Z_RES, Z_MEXT: mz = LV[DW-1:0];
      Z_ADD:        mz = addend;
      Z_CSHR:       mz = CS >> ZSHIFT;
      Z_RSHR:       mz = LV[DW-1:0] >> ZSHIFT;
      default:      mz = '0;
    endcase
    case (c.csel)
      C_FABRIC: mc = f;
      C_NCSUM:  mc = ~CS[DW-1];
      C_CASCIN: mc = ~f;
      C_CSUM:   mc = CS[DW-1];
      C_FEEDBK: mc = LV[DW];
      C_NRES:   mc = ~LV[DW-1];
      C_ROUND:  mc = ~(mma[MAW-1] ^ mmb[BW-1]);
      default:  mc = LV[DW-1];
    endcase
    case (c.alu)
      ALU_ADD:   ma = mz + mx + my + DW'(mc);
      ALU_NZADD: ma = ~mz + mx + my + DW'(mc);
      ALU_NSUM:  ma = ~(mz + mx + my + DW'(mc));
      ALU_SUB:   ma = mz - (mx + my + DW'(mc));
      default:   ma = '0;
    endcase
  endfunction : model

  task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_now(input dspoc_ctrl_t c, input logic [IMW-1:0] im, input logic f);
    model(c, im, f);
    cmp(ox, mx);
    cmp(oy, my);
    cmp(oz, mz);
    cmp(DW'(oc), DW'(mc));
    cmp(oalu, ma);
    cmp(DW'(oma), DW'(mma));
    cmp(DW'(omb), DW'(mmb));
  endtask : chk_now

  // new controls each edge; checks the answer to the previous ones
  task automatic go(input dspoc_ctrl_t c, input logic [IMW-1:0] im);
    @(posedge clk) ctrl <= c;
    imode <= im;
    fab <= ^c;
    cci <= ~^c;
    @(negedge clk) chk_now(pc, pim, ^pc);
    pc = c;
    pim = im;
  endtask : go

  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge clk) raddr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [REG_AW-1:0] a, input logic [31:0] x);
    @(posedge clk) raddr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) cmp(DW'(rdata), DW'(x));
  endtask : reg_read

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // a hang ends the run as a mismatch
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  // ************
  // main sequence
  // ************
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) cmp(ox | oy | oz | oalu | DW'({oma, omb, oc}) | DW'(rdata), '0);
    @(posedge clk) srst <= 1'b0;
    @(posedge clk) ld <= 1'b1;
    @(posedge clk) ld <= 1'b0;
    reg_read(OFS_CFG, CFG_RST);
    reg_read(4'h8, 32'h0);
    reg_write(OFS_CFG, 32'h0000_0040);
    reg_write(OFS_STAT, 32'hFFFF_FFFF);
    reg_read(OFS_CFG, 32'h0000_0040);
    reg_read(OFS_STAT, 32'h0);
    for (int i = 0; i < 32; i++) begin
      go('0, 5'(i));
    end
    // every legal select back to back; illegal pairings are never applied
    for (int i = 0; i < 128; i++) begin
      c1 = '{opsel: 7'(i), alu: 4'((i / 3) % 4), csel: 3'((i / 5) % 8)};
      if (c1.opsel[6:4] != 3'h7 && (c1.opsel[1:0] == X_PROD) == (c1.opsel[3:2] == Y_PROD)
          && (c1.opsel[6:4] != Z_MEXT || c1.opsel[3:0] == 4'h8)) begin
        go(c1, '0);
      end
    end
    go('{opsel: {Z_ZERO, Y_ADD, X_ZERO}, alu: ALU_ADD, csel: C_FABRIC}, '0);
    reg_write(OFS_CFG, 32'h0000_0240);
    @(posedge clk) addend <= 48'h0000_3333_4444;
    aen <= 1'b0;
    repeat (4) @(negedge clk);
    cmp(oy, A_OLD);
    @(posedge clk) aen <= 1'b1;
    // third sample still old only when both stages are really in the path
    repeat (3) @(negedge clk);
    cmp(oy, A_OLD);
    @(negedge clk);
    cmp(oy, addend);
    // registered controls answer one edge later than flow-through
    reg_write(OFS_CFG, 32'h0000_004E);
    c1 = '{opsel: {Z_ADD, Y_ZERO, X_AB}, alu: ALU_SUB, csel: C_CASCIN};
    c2 = '{opsel: {Z_CSUM, Y_ONES, X_AB}, alu: ALU_NSUM, csel: C_CASCIN};
    go(c1, '0);
    @(negedge clk);
    @(negedge clk) chk_now(c1, '0, ^c1);
    @(posedge clk) op_en <= 1'b0;
    go(c2, '0);
    e = c2;
    e.opsel = c1.opsel;
    @(negedge clk);
    @(negedge clk) chk_now(e, '0, ^c2);
    @(posedge clk) op_en <= 1'b1;
    ctrl_rst <= 1'b1;
    @(posedge clk) ctrl_rst <= 1'b0;
    repeat (2) @(negedge clk);
    e = '{opsel: '0, alu: ALU_NSUM, csel: '0};
    chk_now(e, '0, ^c2);
    @(posedge clk) alu_rst <= 1'b1;
    @(posedge clk) alu_rst <= 1'b0;
    repeat (2) @(negedge clk);
    e = c2;
    e.alu = ALU_ADD;
    chk_now(e, '0, ^c2);
    // registered input mode: frozen while its enable is low, then one edge late
    reg_write(OFS_CFG, 32'h0000_0001);
    @(posedge clk) imode <= 5'h11;
    im_en <= 1'b0;
    repeat (2) @(negedge clk);
    cmp(DW'(oma), DW'(A2[MAW-1:0]));
    @(posedge clk) im_en <= 1'b1;
    repeat (3) @(negedge clk);
    cmp(DW'(oma), DW'(A1[MAW-1:0]));
    @(posedge clk) imode <= 5'h12;
    repeat (3) @(negedge clk);
    cmp(DW'(oma), '0);
    tally_and_finish();
  end
endmodule : dspoc_operand_ctrl_tb
